// File: hw/adcc_core.sv
/*
 * Control and sequencing of the shared 10-bit successive-approximation
 * converter: register port, converter clock, channel routing, ADC and DAC
 * sequences, completion flag.
 * Assumes a comparator output from the analog array, an 8 MHz internal
 * oscillator level, timer overflow pulses and an interrupt-vector pulse
 * from same-clock logic. The system oscillator is mclk_i itself.
 */
// Implementation choices: the register offsets and strobed register access.
// What this block does
// RULE_01: ADC mode yields a 10-bit two's complement result by successive approximation.
// RULE_02: differential_select picks single-ended against half supply, or pin-pair difference.
// RULE_03: channel_select picks one of six pins, or one of three pin pairs.
// RULE_04: selected pins are connected only while input_connect is one.
// RULE_05: software clears input_connect before changing channel_select, then sets it.
// RULE_06: software leaves input_connect and channel_select alone during a conversion.
// RULE_07: software sets converter input pins to input-only mode.
// RULE_08: channel six routes supply monitor or temperature sensor, internal reference negative.
// RULE_09: converter works and draws power only while converter_enable is set.
// RULE_10: ADC conversion lasts 13 converter cycles, sampling in the third.
// RULE_11: conversion end sets the done flag; ADC mode also stores the result.
// RULE_12: done flag shows one converter cycle plus synchronisation later.
// RULE_13: in ADC mode result registers are read-only and hold until next result.
// RULE_14: DAC mode needs enable and analog_output_mode; output is always differential.
// RULE_15: DAC mode ignores differential_select, input_connect and channel_select.
// RULE_16: while DAC mode is on, the two output port bits are forced input-only.
// RULE_17: DAC conversion lasts 11 cycles, builds from cycle 2, shows at cycle 7.
// RULE_18: in DAC mode result registers are write-only, buffered for the whole conversion.
// RULE_19: software keeps converter clock at or below the system clock in DAC mode.
// RULE_20: default converter clock is 2 MHz from the internal 8 MHz oscillator.
// RULE_21: otherwise the clock comes from the system oscillator via a 7-bit prescaler.
// RULE_22: writing start_busy with enable set starts one conversion; cleared on completion. The code ignores the write unless trig selects software start.
// RULE_23: a selected timer overflow starts a conversion and sets start_busy.
// RULE_24: right adjust sign-extends the upper six bits; left adjust zeroes the lower six.
// RULE_25: vectoring to the converter interrupt routine clears the done flag.
// RULE_26: each prescale code is a power-of-two division; code zero is the internal clock.
// RULE_27: the converter clock is treated as asynchronous; flag and start are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.svh"

module adcc_core (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // analog side inputs
    input wire logic osc8_i,
    input wire logic comp_i,
    // system events
    input wire logic [2:0] timer_ovf_i,
    input wire logic isr_vector_i,
    // analog array control
    output logic [9:0] sar_code_o,
    output logic sample_hold_o,
    output logic dac_update_o,
    output logic conv_power_o,
    output logic dac_mode_o,
    output logic [5:0] pin_connect_o,
    output logic mid_ref_o,
    output logic int_ref_neg_o,
    output logic [1:0] int_src_o,
    output logic [1:0] p2_force_input_o,
    output logic int_osc_run_o,
    // status
    output logic done_flag_o,
    output logic busy_o
);

    adcc_pkg::adcc_state_rec_type s_r;
    adcc_pkg::adcc_state_rec_type s_nxt;

    // channel routing: {mid_ref, int_ref_neg, int_src[1:0], pins[5:0]}
    function automatic logic [9:0] route_map(input logic on, input logic differential_select,
                                             input logic [2:0] chan, input logic isel);
        logic [9:0] r;
        r = 10'h000;
        if (on) begin
            if (chan == `ADCC_CHAN_INTERNAL) begin
                r[8] = 1'b1; // RULE_08
                r[7:6] = isel ? 2'b10 : 2'b01; // RULE_08
            end else if (differential_select) begin
                if (chan <= `ADCC_CHAN_LAST_PAIR) begin
                    r[{chan[1:0], 1'b0}] = 1'b1; // RULE_03
                    r[{chan[1:0], 1'b1}] = 1'b1; // RULE_02
                end
            end else if (chan <= `ADCC_CHAN_LAST_PIN) begin
                r[chan] = 1'b1; // RULE_03
                r[9] = 1'b1; // RULE_02
            end
        end
        return r;
    endfunction

    // one SAR decision: drop the trial bit if the input is below, then try the next
    function automatic logic [9:0] sar_step(input logic [9:0] code, input logic [3:0] b,
                                            input logic keep);
        logic [9:0] r;
        r = code;
        if (!keep) begin
            r[b] = 1'b0;
        end
        if (b != 4'h0) begin
            r[b - 4'h1] = 1'b1;
        end
        return r;
    endfunction

    // the SAR works in offset binary; flipping the top bit gives two's complement
    function automatic logic [15:0] fmt_result(input logic [9:0] code, input logic left);
        logic [9:0] v;
        v = {~code[9], code[8:0]}; // RULE_01
        return left ? {v, 6'h00} : {{6{v[9]}}, v}; // RULE_24
    endfunction

    // converter clock ticks, conversion sequencer and register port
    always_comb begin
        logic start_req;
        logic rd_sel;
        logic fin;
        logic set_done;
        logic [2:0] ovf;
        start_req = 1'b0;
        rd_sel = 1'b0;
        fin = 1'b0;
        set_done = 1'b0;
        ovf = timer_ovf_i;
        s_nxt = s_r;
        s_nxt.rdata = `ADCC_RST_BYTE;

        // asynchronous oscillator and comparator pass two flops first
        s_nxt.osc_s1 = osc8_i; // RULE_27
        s_nxt.osc_s2 = s_r.osc_s1;
        s_nxt.osc_s3 = s_r.osc_s2;
        s_nxt.cmp_s1 = comp_i;
        s_nxt.cmp_s2 = s_r.cmp_s1;

        // tick generation; the prescaler runs free so a code change needs no reload
        s_nxt.presc = s_r.presc + 7'h01;
        s_nxt.tick = 1'b0;
        if (s_r.osc_s2 && !s_r.osc_s3) begin
            s_nxt.osc_cnt = s_r.osc_cnt + 2'h1;
        end
        if (s_r.clk_sel == `ADCC_CLK_INTERNAL) begin
            s_nxt.tick = s_r.osc_s2 && !s_r.osc_s3 && s_r.osc_cnt == `ADCC_OSC_DIV_LAST; // RULE_20
        end else begin
            s_nxt.tick = &(s_r.presc | ~((7'h01 << s_r.clk_sel) - 7'h01)); // RULE_21 RULE_26
        end
        s_nxt.osc_run = s_r.conv_en && s_r.clk_sel == `ADCC_CLK_INTERNAL; // RULE_20

        // static outputs follow the mode bits
        s_nxt.power = s_r.conv_en; // RULE_09
        s_nxt.p2_force = {2{s_r.conv_en && s_r.dac_mode}}; // RULE_16
        s_nxt.route = route_map(s_r.conv_en && !s_r.dac_mode && s_r.input_connect,
                                s_r.differential_select_sel, s_r.chan, s_r.int_sel); // RULE_04 RULE_15

        // register writes
        if (wr_i) begin
            unique case (addr_i)
                `ADCC_OFF_CTRL: begin
                    s_nxt.dac_mode = wdata_i[`ADCC_CTRL_DACM];
                    s_nxt.conv_en = wdata_i[`ADCC_CTRL_EN];
                    s_nxt.left_adj = wdata_i[`ADCC_CTRL_LEFT];
                    s_nxt.clk_sel = wdata_i[`ADCC_CTRL_CLK_HI:`ADCC_CTRL_CLK_LO];
                    if (!wdata_i[`ADCC_CTRL_DONE]) begin
                        s_nxt.done = 1'b0;
                    end
                    if (wdata_i[`ADCC_CTRL_BUSY] && wdata_i[`ADCC_CTRL_EN]
                        && s_r.trig == `ADCC_TRIG_SOFT) begin
                        start_req = 1'b1; // RULE_22
                    end
                end
                `ADCC_OFF_INPUT: begin
                    s_nxt.input_connect = wdata_i[`ADCC_IN_CONNECT];
                    s_nxt.trig = wdata_i[`ADCC_IN_TRIG_HI:`ADCC_IN_TRIG_LO];
                    s_nxt.int_sel = wdata_i[`ADCC_IN_INTSEL];
                    s_nxt.differential_select_sel = wdata_i[`ADCC_IN_DIFFERENTIAL_SELECT];
                    s_nxt.chan = wdata_i[`ADCC_IN_CHAN_HI:`ADCC_IN_CHAN_LO];
                end
                `ADCC_OFF_RES_LOW: begin
                    if (s_r.dac_mode) begin
                        s_nxt.data_pair[7:0] = wdata_i; // RULE_13 RULE_18
                    end
                end
                `ADCC_OFF_RES_HIGH: begin
                    if (s_r.dac_mode) begin
                        s_nxt.data_pair[15:8] = wdata_i; // RULE_13 RULE_18
                    end
                end
                default: begin
                end
            endcase
        end

        // timer-triggered start
        if (s_r.conv_en && s_r.trig != `ADCC_TRIG_SOFT && ovf[s_r.trig - 2'h1]) begin
            start_req = 1'b1; // RULE_23
        end
        if (start_req && s_r.state == adcc_pkg::st_idle && !s_r.pend) begin
            s_nxt.pend = 1'b1; // RULE_27
            s_nxt.busy = 1'b1; // RULE_22 RULE_23
        end

        // sequencer advances on converter ticks only
        unique case (s_r.state)
            adcc_pkg::st_idle: begin
                s_nxt.sample_hold = 1'b0;
                if (s_r.pend && s_r.tick) begin
                    s_nxt.pend = 1'b0;
                    s_nxt.state = adcc_pkg::st_conv;
                    s_nxt.cyc = `ADCC_FIRST_CYCLE;
                    s_nxt.sar = `ADCC_RST_WORD;
                    s_nxt.dac_update = 1'b0;
                    s_nxt.dac_buf = s_r.left_adj ? s_r.data_pair[15:6]
                                                 : s_r.data_pair[9:0]; // RULE_18
                end
            end
            adcc_pkg::st_conv: begin
                if (s_r.tick) begin
                    s_nxt.cyc = s_r.cyc + 4'h1;
                    if (s_r.dac_mode) begin
                        if (s_r.cyc == `ADCC_DAC_CYCLES) begin
                            fin = 1'b1; // RULE_17
                        end else begin
                            s_nxt.sar[4'ha - s_r.cyc] = s_r.dac_buf[4'ha - s_r.cyc]; // RULE_17
                        end
                        if (s_r.cyc + 4'h1 == `ADCC_DAC_SHOW_CYCLE) begin
                            s_nxt.dac_update = 1'b1; // RULE_17
                        end
                    end else begin
                        s_nxt.sample_hold = s_r.cyc + 4'h1 == `ADCC_SAMPLE_CYCLE; // RULE_10
                        if (s_r.cyc == `ADCC_SAMPLE_CYCLE) begin
                            s_nxt.sar = `ADCC_SAR_MSB; // RULE_01
                        end else if (s_r.cyc >= `ADCC_FIRST_BIT_CYCLE) begin
                            s_nxt.sar = sar_step(s_r.sar, `ADCC_ADC_CYCLES - s_r.cyc,
                                                 s_r.cmp_s2); // RULE_01
                        end
                        if (s_r.cyc == `ADCC_ADC_CYCLES) begin
                            fin = 1'b1; // RULE_10
                            s_nxt.data_pair = fmt_result(sar_step(s_r.sar, 4'h0, s_r.cmp_s2),
                                                         s_r.left_adj); // RULE_11
                        end
                    end
                    if (fin) begin
                        s_nxt.state = adcc_pkg::st_flag;
                    end
                end
            end
            adcc_pkg::st_flag: begin
                if (s_r.tick) begin
                    set_done = 1'b1; // RULE_11 RULE_12
                    s_nxt.busy = 1'b0; // RULE_22
                    s_nxt.state = adcc_pkg::st_idle;
                end
            end
        endcase

        // done flag: vector clears it, a coincident set wins
        if (isr_vector_i) begin
            s_nxt.done = 1'b0; // RULE_25
        end
        if (set_done) begin
            s_nxt.done = 1'b1; // RULE_11
        end

        // dropping the enable aborts everything and powers down
        if (!s_nxt.conv_en) begin
            s_nxt.state = adcc_pkg::st_idle; // RULE_09
            s_nxt.pend = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.sample_hold = 1'b0;
            s_nxt.dac_update = 1'b0;
        end

        // reads answer in the next cycle only
        if (rd_i) begin
            rd_sel = 1'b1;
            unique case (addr_i)
                `ADCC_OFF_CTRL: s_nxt.rdata = {s_r.done, s_r.busy, s_r.dac_mode, s_r.conv_en,
                                               s_r.left_adj, s_r.clk_sel};
                `ADCC_OFF_INPUT: s_nxt.rdata = {s_r.input_connect, s_r.trig, s_r.int_sel,
                                                s_r.differential_select_sel, s_r.chan};
                `ADCC_OFF_RES_LOW: s_nxt.rdata = s_r.dac_mode ? `ADCC_RST_BYTE
                                                              : s_r.data_pair[7:0]; // RULE_18
                `ADCC_OFF_RES_HIGH: s_nxt.rdata = s_r.dac_mode ? `ADCC_RST_BYTE
                                                               : s_r.data_pair[15:8]; // RULE_18
                default: rd_sel = 1'b0;
            endcase
        end
    end

    // the whole state in one register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r <= '0;
            s_r.state <= adcc_pkg::st_idle;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign rdata_o = s_r.rdata;
    assign sar_code_o = s_r.sar;
    assign sample_hold_o = s_r.sample_hold;
    assign dac_update_o = s_r.dac_update;
    assign conv_power_o = s_r.power;
    assign dac_mode_o = s_r.p2_force[0]; // RULE_14
    assign pin_connect_o = s_r.route[5:0];
    assign int_src_o = s_r.route[7:6];
    assign int_ref_neg_o = s_r.route[8];
    assign mid_ref_o = s_r.route[9];
    assign p2_force_input_o = s_r.p2_force;
    assign int_osc_run_o = s_r.osc_run;
    assign done_flag_o = s_r.done;
    assign busy_o = s_r.busy;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    sequence start_taken;
        s_r.state == adcc_pkg::st_idle && s_r.pend && s_r.tick && s_r.conv_en;
    endsequence
    sequence first_cycle;
        s_r.state == adcc_pkg::st_conv && s_r.cyc == `ADCC_FIRST_CYCLE && s_r.busy;
    endsequence

    start_seq_a: assert property (start_taken ##0 wr_i == 1'b0 |=> first_cycle) // RULE_22
        else $error("start not taken on converter tick");
    done_set_a: assert property (s_r.state == adcc_pkg::st_flag && s_r.tick && s_r.conv_en
        |=> s_r.done && !s_r.busy) // RULE_11
        else $error("done flag not set after final cycle");
    sample_third_a: assert property (s_r.sample_hold |-> s_r.cyc == 4'h3 && !s_r.dac_mode) // RULE_10
        else $error("sample outside third cycle");
    adc_len_a: assert property (s_r.state == adcc_pkg::st_conv && !s_r.dac_mode
        && s_r.cyc == 4'hd && s_r.tick && s_r.conv_en |=> s_r.state == adcc_pkg::st_flag) // RULE_10
        else $error("adc conversion length wrong");
    dac_len_a: assert property (s_r.state == adcc_pkg::st_conv && s_r.dac_mode
        && s_r.tick && s_r.conv_en && s_r.cyc < 4'hb |=> s_r.state != adcc_pkg::st_flag) // RULE_17
        else $error("dac conversion ended early");
    dac_show_a: assert property ($rose(s_r.dac_update) |-> s_r.cyc == 4'h7) // RULE_17
        else $error("dac output released at wrong cycle");
    p2_force_a: assert property (s_r.conv_en && s_r.dac_mode |=> p2_force_input_o == 2'b11) // RULE_16
        else $error("output pins not forced input-only");
    result_ro_a: assert property (wr_i && !s_r.dac_mode && s_r.state != adcc_pkg::st_conv
        |=> $stable(s_r.data_pair)) // RULE_13
        else $error("result changed by write in adc mode");
    dac_buf_a: assert property (s_r.state == adcc_pkg::st_conv ##1 s_r.state == adcc_pkg::st_conv
        |-> $stable(s_r.dac_buf)) // RULE_18
        else $error("dac buffer changed during conversion");
    isr_clear_a: assert property (isr_vector_i && !(s_r.state == adcc_pkg::st_flag && s_r.tick)
        |=> !s_r.done) // RULE_25
        else $error("vector did not clear done flag");
    power_off_a: assert property (!s_r.conv_en |=> !conv_power_o ##1 !s_r.busy || s_r.conv_en) // RULE_09
        else $error("converter powered while disabled");

endmodule
`default_nettype wire

// File: hw/adcc_defs.svh
/*
 * Register offsets, field positions, reset values and cycle counts of the
 * converter control block.
 * Assumes it is included by bare name after adcc_pkg has been compiled.
 */
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// register offsets on the byte-wide register port
`define ADCC_OFF_CTRL 8'ha4
`define ADCC_OFF_INPUT 8'ha5
`define ADCC_OFF_RES_LOW 8'ha2
`define ADCC_OFF_RES_HIGH 8'ha3

// converter_control fields
`define ADCC_CTRL_DONE 7
`define ADCC_CTRL_BUSY 6
`define ADCC_CTRL_DACM 5
`define ADCC_CTRL_EN 4
`define ADCC_CTRL_LEFT 3
`define ADCC_CTRL_CLK_HI 2
`define ADCC_CTRL_CLK_LO 0

// converter_input_control fields
`define ADCC_IN_CONNECT 7
`define ADCC_IN_TRIG_HI 6
`define ADCC_IN_TRIG_LO 5
`define ADCC_IN_INTSEL 4
`define ADCC_IN_DIFFERENTIAL_SELECT 3
`define ADCC_IN_CHAN_HI 2
`define ADCC_IN_CHAN_LO 0

// reset values
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_PAIR 16'h0000
`define ADCC_RST_WORD 10'h000

// codes
`define ADCC_CLK_INTERNAL 3'h0
`define ADCC_TRIG_SOFT 2'h0
`define ADCC_CHAN_INTERNAL 3'h6
`define ADCC_CHAN_LAST_PIN 3'h5
`define ADCC_CHAN_LAST_PAIR 3'h2
`define ADCC_SAR_MSB 10'h200

// cycle counts in converter clock cycles
`define ADCC_ADC_CYCLES 4'hd
`define ADCC_DAC_CYCLES 4'hb
`define ADCC_SAMPLE_CYCLE 4'h3
`define ADCC_FIRST_BIT_CYCLE 4'h4
`define ADCC_DAC_BUILD_CYCLE 4'h2
`define ADCC_DAC_SHOW_CYCLE 4'h7
`define ADCC_FIRST_CYCLE 4'h1

// internal source: 8 MHz oscillator divided by 4 gives 2 MHz
`define ADCC_OSC_DIV_LAST 2'h3

`endif

// File: hw/adcc_pkg.sv
/*
 * Types of the converter control block: state codes and the state record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adcc_pkg;

    // one-hot conversion sequencer states
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_conv = 3'b010,
        st_flag = 3'b100
    } adcc_state_type;

    // complete register state of the block
    typedef struct packed {
        adcc_state_type state;
        logic [3:0] cyc;
        logic pend;
        logic busy;
        logic done;
        logic conv_en;
        logic dac_mode;
        logic left_adj;
        logic [2:0] clk_sel;
        logic input_connect;
        logic [1:0] trig;
        logic int_sel;
        logic differential_select_sel;
        logic [2:0] chan;
        logic [15:0] data_pair;
        logic [9:0] dac_buf;
        logic [9:0] sar;
        logic sample_hold;
        logic dac_update;
        logic [7:0] rdata;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic [1:0] osc_cnt;
        logic [6:0] presc;
        logic cmp_s1;
        logic cmp_s2;
        logic tick;
        logic [9:0] route;
        logic [1:0] p2_force;
        logic osc_run;
        logic power;
    } adcc_state_rec_type;

endpackage

// File: tb/adcc_analog_model.sv
/*
 * model of the analog side: free-running internal oscillator and a comparator
 * holding one input level against the trial code.
 * assumes the trial code is offset binary and the bench sets the level.
 */
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
    // from the block and the bench
    input wire logic [9:0] sar_code_i,
    input wire logic [9:0] level_i,
    // to the block
    output logic osc8_o,
    output logic comp_o
);
    // 8 MHz oscillator runs whether or not anyone uses it
    initial begin
        osc8_o = 1'b0;
        forever #62.5 osc8_o = ~osc8_o;
    end
    // held level on an input-only pin, so the answer moves only with the trial code
    assign comp_o = (level_i >= sar_code_i);
endmodule
`default_nettype wire

// File: tb/tb_adcc_core.sv
/*
 * self-checking bench of the converter control block.
 * assumes the analog model answers the comparator; converter clock is mclk/4
 * or the internal 2 MHz source.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_core;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [2:0] timer_ovf_i = 3'h0;
    logic isr_vector_i = 1'b0;
    logic [9:0] level = 10'h000;
    logic [7:0] rdata_o;
    logic [9:0] sar_code_o;
    logic [5:0] pin_connect_o;
    logic [1:0] int_src_o, p2_force_input_o;
    logic osc8, comp, sample_hold_o, dac_update_o, conv_power_o, dac_mode_o, mid_ref_o;
    logic int_ref_neg_o, int_osc_run_o, done_flag_o, busy_o, sh_seen, upd_seen;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    adcc_analog_model model_u (.sar_code_i(sar_code_o), .level_i(level), .osc8_o(osc8),
        .comp_o(comp));
    adcc_core dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc8_i(osc8), .comp_i(comp),
        .timer_ovf_i(timer_ovf_i), .isr_vector_i(isr_vector_i), .sar_code_o(sar_code_o),
        .sample_hold_o(sample_hold_o), .dac_update_o(dac_update_o),
        .conv_power_o(conv_power_o), .dac_mode_o(dac_mode_o), .pin_connect_o(pin_connect_o),
        .mid_ref_o(mid_ref_o), .int_ref_neg_o(int_ref_neg_o), .int_src_o(int_src_o),
        .p2_force_input_o(p2_force_input_o), .int_osc_run_o(int_osc_run_o),
        .done_flag_o(done_flag_o), .busy_o(busy_o));

    // 40 MHz clock
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    // hang guard, well above the fewer than one thousand cycles the tests need
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // register port cycles; read data stand only in the cycle after the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask
    // bounded wait for the done flag, noting sample and update strobes
    task automatic wait_done;
        sh_seen = 1'b0;
        upd_seen = 1'b0;
        for (int i = 0; i < 1000 && done_flag_o !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
            sh_seen = sh_seen | (sample_hold_o === 1'b1);
            upd_seen = upd_seen | (dac_update_o === 1'b1);
        end
    endtask

    // reset values and an unmapped read
    task automatic t_reset;
        logic [7:0] d;
        rd(8'ha4, d);
        chk("ctrl reset", 16'h0000, {8'h00, d});
        rd(8'ha5, d);
        chk("input reset", 16'h0000, {8'h00, d});
        rd(8'h10, d);
        chk("unmapped read", 16'h0000, {8'h00, d});
    endtask
    // channel routing table; connect is cleared before each channel change
    task automatic t_route;
        logic [7:0] cfg[6] = '{8'h05, 8'h85, 8'h88, 8'h8a, 8'h86, 8'h96};
        logic [5:0] pins[6] = '{6'h00, 6'h20, 6'h03, 6'h30, 6'h00, 6'h00};
        logic [1:0] src[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
        // routing only follows the channel while the converter is enabled
        wr(8'ha4, 8'h10);
        settle();
        chk("internal osc run", 16'h0001, {15'h0000, int_osc_run_o});
        for (int i = 0; i < 6; i++) begin
            wr(8'ha5, cfg[i] & 8'h7f);
            wr(8'ha5, cfg[i]);
            settle();
            chk("pin connect", {10'h000, pins[i]}, {10'h000, pin_connect_o});
            chk("internal source", {14'h0000, src[i]}, {14'h0000, int_src_o});
            chk("neg ref", {15'h0000, i >= 4}, {15'h0000, int_ref_neg_o});
        end
    endtask
    // one software-started ADC conversion with result alignment
    task automatic t_adc(input logic [9:0] lvl, input logic left);
        logic [7:0] lo, hi;
        logic [9:0] r;
        logic [15:0] exp;
        level = lvl;
        r = lvl ^ 10'h200;
        exp = left ? {r, 6'h00} : {{6{r[9]}}, r};
        wr(8'ha5, 8'h01);
        wr(8'ha5, 8'h81);
        wr(8'ha4, {4'h5, left, 3'h2});
        settle();
        chk("single-ended pin", 16'h0003, {14'h0000, pin_connect_o[1], mid_ref_o});
        chk("busy at start", 16'h0003, {14'h0000, busy_o, conv_power_o});
        wait_done();
        chk("done and busy", 16'h0002, {14'h0000, done_flag_o, busy_o});
        chk("sample strobe", 16'h0001, {15'h0000, sh_seen});
        wr(8'ha2, 8'h55);
        rd(8'ha2, lo);
        rd(8'ha3, hi);
        chk("result pair", exp, {hi, lo});
        chk("result read only", {8'h00, exp[7:0]}, {8'h00, lo});
        @(posedge mclk_i);
        isr_vector_i <= 1'b1;
        @(posedge mclk_i);
        isr_vector_i <= 1'b0;
        settle();
        chk("done cleared", 16'h0000, {15'h0000, done_flag_o});
    endtask
    // timer trigger: only the selected timer starts a conversion
    task automatic t_timer;
        wr(8'ha4, 8'h10);
        wr(8'ha5, 8'hc1);
        for (int t = 0; t < 2; t++) begin
            @(posedge mclk_i);
            timer_ovf_i <= 3'h1 << t;
            @(posedge mclk_i);
            timer_ovf_i <= 3'h0;
            settle();
            chk("timer start", {15'h0000, t[0]}, {15'h0000, busy_o});
        end
        wait_done();
        chk("timer done", 16'h0002, {14'h0000, done_flag_o, busy_o});
        wr(8'ha4, 8'h12);
        // back to software start, else the next start_busy write is ignored
        wr(8'ha5, 8'h01);
    endtask
    // DAC conversion: buffered word, output update, forced pins, disable
    task automatic t_dac;
        logic [7:0] d;
        wr(8'ha4, 8'h32);
        wr(8'ha2, 8'ha5);
        wr(8'ha3, 8'h02);
        settle();
        chk("dac mode pins", 16'h0007, {13'h0000, dac_mode_o, p2_force_input_o});
        wr(8'ha4, 8'h72);
        // let the start tick capture the word before overwriting it
        settle();
        wr(8'ha2, 8'h00);
        wait_done();
        chk("dac update", 16'h0001, {15'h0000, upd_seen});
        chk("dac word held", 16'h02a5, {6'h00, sar_code_o});
        rd(8'ha2, d);
        chk("dac result unreadable", 16'h0000, {8'h00, d});
        wr(8'ha4, 8'h00);
        settle();
        chk("disabled", 16'h0000, {13'h0000, conv_power_o, p2_force_input_o});
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_route();
        t_adc(10'h0ff, 1'b0);
        t_adc(10'h3ff, 1'b0);
        t_adc(10'h000, 1'b1);
        t_timer();
        t_dac();
        end_of_test();
    end
endmodule
`default_nettype wire
